// ---- src/gwei_pkg.sv ----
// constants and carrier types for the pin wake monitor and external line block
// assumes a single 125 MHz system clock; pins are numbered port A 0-7, B 8-15, C 16-23
package gwei_pkg;

    // ----------------------------------------------------------------
    // sizes and fixed pins
    // ----------------------------------------------------------------
    localparam int NUM_PINS   = 24;
    localparam int NUM_LINES  = 4;
    localparam int LINE_A_PIN = 8;
    localparam int LINE_B_PIN = 14;
    localparam int SEL_W      = 5;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 125_000_000;
    localparam int WAKE_FILT_HZ  = 10_000;
    localparam int WAKE_TICK_CYC = CLK_HZ / WAKE_FILT_HZ;
    localparam int WAKE_SAMPLES  = 3;
    localparam int LINE_FILT_NS  = 450;
    // longest stable time that still lets a 450 ns pulse through: round down
    localparam int LINE_FILT_CYC = (LINE_FILT_NS * (CLK_HZ / 1_000_000)) / 1000;

    // ----------------------------------------------------------------
    // trigger mode codes
    // ----------------------------------------------------------------
    localparam logic [2:0] TRIG_OFF  = 3'h0;
    localparam logic [2:0] TRIG_RISE = 3'h1;
    localparam logic [2:0] TRIG_FALL = 3'h2;
    localparam logic [2:0] TRIG_BOTH = 3'h3;
    localparam logic [2:0] TRIG_HIGH = 3'h4;
    localparam logic [2:0] TRIG_LOW  = 3'h5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic RST_DEBUG_DISABLE = 1'h0;
    localparam logic RST_BOOT_CAPTURED = 1'h1;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic line_d;
        logic sc2;
        logic sc1;
        logic pins;
    } gwei_wake_src_t;

    typedef struct packed {
        logic       line_filter_enable;
        logic [2:0] trigger_mode_field;
    } gwei_line_cfg_t;

    typedef struct packed {
        logic debugger_forced_flag;
        logic serial_wire_enabled_flag;
        logic boot_pin_captured;
    } gwei_dbg_stat_t;

endpackage

// ---- src/gwei_top.sv ----
// pin change wake monitor, four external interrupt lines and debug config/status bits
// assumes all inputs are synchronous to clk_sys except pin_in, which is synchronised here;
// software side bits arrive as plain ports, write strobes are one-cycle pulses
//
// Operation
// - per-pin wake mask; only masked-in pins are wake sources
// - pin levels are latched as reference on entry to sleep
// - while asleep any masked pin differing from reference wakes; no edge choice
// - record that pins caused the wake, not which pin
// - separate filter enables for pins, serial one, serial two, line d
// - filter samples at 10 kHz; three equal samples differing from reference wake
// - pin wake works only with the pin wake source select bit set
// - analog pins read as constant 1, so only the switch to analog or a high-level trigger can wake or interrupt
// - four external lines a to d, each with its own request output
// - line detection taps the ordinary input path in all non-analog modes
// - trigger modes: off, rise, fall, both, high level, low level
// - per-line filter; unfiltered catches short pulses, filtered needs 450 ns
// - pending flag per line; writing one clears, zero leaves alone
// - level line sets its flag again the cycle after a clear if still active
// - lines a and b on fixed pins; c and d from own pin select
// - select 0-7 port A, 8-15 port B, 16-23 port C
// - debug status reports forced flag, serial wire flag, captured boot pin
// - debug config holds a bit that disables the debugger
`timescale 1ns/1ps
module gwei_top
    import gwei_pkg::*;
#(
    parameter int WAKE_TICK = WAKE_TICK_CYC,
    parameter int LINE_FILT = LINE_FILT_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     arst_n,
    input  wire logic [NUM_PINS-1:0]      pin_in,
    input  wire logic [NUM_PINS-1:0]      pin_analog,
    input  wire logic [NUM_PINS-1:0]      pin_wake_mask,
    input  wire gwei_wake_src_t           wake_src_select,
    input  wire gwei_wake_src_t           wake_filter_enables,
    input  wire logic                     serial_ctrl_one,
    input  wire logic                     serial_ctrl_two,
    input  wire logic                     sleep_active,
    input  wire gwei_line_cfg_t [3:0]     ext_line_config,
    input  wire logic [SEL_W-1:0]         line_c_pin_select,
    input  wire logic [SEL_W-1:0]         line_d_pin_select,
    input  wire logic [NUM_LINES-1:0]     flag_clear_wr,
    input  wire logic                     debug_config_wr,
    input  wire logic                     debug_disable_wdata,
    input  wire logic                     debugger_active,
    input  wire logic                     debugger_forced_in,
    input  wire logic                     serial_wire_in,
    input  wire logic                     boot_select_pin_n,
    input  wire logic                     boot_sample,
    output logic                          wake_event,
    output gwei_wake_src_t                wake_cause,
    output logic [NUM_LINES-1:0]          ext_line_pending_flags,
    output logic [NUM_LINES-1:0]          ext_irq_req,
    output logic                          debug_disable,
    output gwei_dbg_stat_t                debug_status
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (WAKE_TICK < 2) begin : g_chk_tick
        $error("WAKE_TICK must be at least 2");
    end
    if (LINE_FILT < 2) begin : g_chk_filt
        $error("LINE_FILT must be at least 2");
    end

    localparam int NSRC = NUM_PINS + 3;
    localparam int TW   = $clog2(WAKE_TICK);
    localparam int FW   = $clog2(LINE_FILT);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // ----------------------------------------------------------------
    // pin input path
    // ----------------------------------------------------------------
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_lvl;

    wire [NUM_PINS-1:0] pin_digital = pin_in | pin_analog;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta <= '0;
            pin_lvl  <= '0;
        end else begin
            pin_meta <= pin_digital;
            pin_lvl  <= pin_meta;
        end
    end

    // ----------------------------------------------------------------
    // line source selection
    // ----------------------------------------------------------------
    // out-of-range select values read as a steady low, so only low-level mode fires on them
    wire sel_c_ok = line_c_pin_select < SEL_W'(NUM_PINS);
    wire sel_d_ok = line_d_pin_select < SEL_W'(NUM_PINS);
    wire lvl_c = sel_c_ok & pin_lvl[line_c_pin_select];
    wire lvl_d = sel_d_ok & pin_lvl[line_d_pin_select];
    wire [NUM_LINES-1:0] line_raw = {lvl_d, lvl_c, pin_lvl[LINE_B_PIN], pin_lvl[LINE_A_PIN]};

    // ----------------------------------------------------------------
    // wake monitor
    // ----------------------------------------------------------------
    logic [NSRC-1:0] wake_ref;
    logic [NSRC-1:0] hist0;
    logic [NSRC-1:0] hist1;
    logic [NSRC-1:0] hist2;
    logic [TW-1:0]   tick_cnt;
    logic            sleep_q;

    wire [NSRC-1:0] wake_src = {lvl_d, serial_ctrl_two, serial_ctrl_one, pin_lvl};
    wire            entry    = sleep_active & ~sleep_q;
    wire            asleep   = sleep_active & sleep_q;
    wire            tick     = tick_cnt == TW'(WAKE_TICK - 1);

    // three equal samples that differ from the reference
    wire [NSRC-1:0] samp_eq   = ~(hist0 ^ hist1) & ~(hist1 ^ hist2);
    wire [NSRC-1:0] filt_hit  = samp_eq & (hist0 ^ wake_ref);
    wire [NSRC-1:0] raw_hit   = wake_src ^ wake_ref;
    // one filter enable per source group
    wire [NSRC-1:0] filt_sel  = {wake_filter_enables.line_d, wake_filter_enables.sc2,
                                 wake_filter_enables.sc1, {NUM_PINS{wake_filter_enables.pins}}};
    wire [NSRC-1:0] src_hit   = (filt_sel & filt_hit) | (~filt_sel & raw_hit);
    wire hit_pins   = wake_src_select.pins & |(src_hit[NUM_PINS-1:0] & pin_wake_mask);
    wire hit_sc1    = wake_src_select.sc1 & src_hit[NUM_PINS];
    wire hit_sc2    = wake_src_select.sc2 & src_hit[NUM_PINS+1];
    wire hit_line_d = wake_src_select.line_d & src_hit[NUM_PINS+2];
    wire gwei_wake_src_t hits = '{line_d: hit_line_d, sc2: hit_sc2, sc1: hit_sc1, pins: hit_pins};

    // free-running divider; up to 100 us of jitter on the first
    // sample is harmless against a 300 us filter
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + TW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sleep_q  <= 1'b0;
            wake_ref <= '0;
            hist0    <= '0;
            hist1    <= '0;
            hist2    <= '0;
        end else begin
            sleep_q <= sleep_active;
            if (entry) begin
                wake_ref <= wake_src;
                hist0    <= wake_src;
                hist1    <= wake_src;
                hist2    <= wake_src;
            end else if (tick) begin
                hist0 <= wake_src;
                hist1 <= hist0;
                hist2 <= hist1;
            end
        end
    end

    // sticky cause per group, not per pin
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wake_event <= 1'b0;
            wake_cause <= '0;
        end else if (entry) begin
            wake_event <= 1'b0;
            wake_cause <= '0;
        end else begin
            wake_event <= sleep_active & (wake_event | (asleep & |hits));
            if (asleep) begin
                wake_cause <= wake_cause | hits;
            end
        end
    end

    AST_REF_LATCH: assert property (entry |=> wake_ref == $past(wake_src))
        else $error("reference not latched at sleep entry");
    AST_PIN_GATE: assert property ($rose(wake_cause.pins) |->
        $past(wake_src_select.pins) && $past(|pin_wake_mask))
        else $error("pin wake without source select or mask");
    AST_RAW_WAKE: assert property (asleep && wake_src_select.pins &&
        !wake_filter_enables.pins && |(raw_hit[NUM_PINS-1:0] & pin_wake_mask)
        |=> wake_event && wake_cause.pins)
        else $error("masked pin change did not wake");

    sequence s_three_ticks_stable;
        (tick && samp_eq[NUM_PINS] && !filt_hit[NUM_PINS]);
    endsequence
    AST_FILT_HOLD: assert property ((asleep && wake_filter_enables.sc1 &&
        !wake_cause.sc1) and s_three_ticks_stable |=> !wake_cause.sc1)
        else $error("filtered source woke without a differing sample run");

    // ----------------------------------------------------------------
    // external interrupt lines
    // ----------------------------------------------------------------
    logic [NUM_LINES-1:0] line_lvl;
    logic [NUM_LINES-1:0] line_prev;
    logic [NUM_LINES-1:0] pend;
    logic [NUM_LINES-1:0] edge_fire;
    logic [NUM_LINES-1:0] lvl_mode;
    logic [NUM_LINES-1:0] lvl_act;

    for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
        logic          filt_q;
        logic [FW-1:0] filt_cnt;
        logic          prev_q;
        logic          pend_q;

        wire [2:0] mode = ext_line_config[i].trigger_mode_field;
        // filtered level needs LINE_FILT steady cycles
        wire use_lvl = ext_line_config[i].line_filter_enable ? filt_q : line_raw[i];
        wire rise    = use_lvl & ~prev_q;
        wire fall    = ~use_lvl & prev_q;
        wire e_fire  = ((mode == TRIG_RISE) & rise) | ((mode == TRIG_FALL) & fall)
                     | ((mode == TRIG_BOTH) & (rise | fall));
        wire is_lvl  = (mode == TRIG_HIGH) | (mode == TRIG_LOW);
        wire act     = ((mode == TRIG_HIGH) & use_lvl) | ((mode == TRIG_LOW) & ~use_lvl);
        // write one clears, set wins on edges
        // level clear wins, re-sets next cycle
        wire next_pend = is_lvl ? (~flag_clear_wr[i] & (pend_q | act))
                                : ((pend_q & ~flag_clear_wr[i]) | e_fire);

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                filt_q   <= 1'b0;
                filt_cnt <= '0;
            end else if (line_raw[i] == filt_q) begin
                filt_cnt <= '0;
            end else if (filt_cnt == FW'(LINE_FILT - 1)) begin
                filt_q   <= line_raw[i];
                filt_cnt <= '0;
            end else begin
                filt_cnt <= filt_cnt + FW'(1);
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                prev_q <= 1'b0;
                pend_q <= 1'b0;
            end else begin
                prev_q <= use_lvl;
                pend_q <= next_pend;
            end
        end

        assign line_lvl[i]  = use_lvl;
        assign line_prev[i] = prev_q;
        assign pend[i]      = pend_q;
        assign edge_fire[i] = e_fire;
        assign lvl_mode[i]  = is_lvl;
        assign lvl_act[i]   = act;

        sequence s_lvl_clear;
            lvl_mode[i] && flag_clear_wr[i];
        endsequence
        sequence s_lvl_still;
            lvl_mode[i] && lvl_act[i] && !flag_clear_wr[i];
        endsequence

        AST_OFF_QUIET: assert property (
            mode == TRIG_OFF && !pend[i] |=> !pend[i])
            else $error("disabled line set its flag");
        AST_RISE_SETS: assert property (
            mode == TRIG_RISE && line_lvl[i] && !line_prev[i] |=> pend[i])
            else $error("rising edge did not set flag");
        AST_W1C: assert property (
            flag_clear_wr[i] && !edge_fire[i] && !lvl_act[i] |=> !pend[i])
            else $error("write one did not clear flag");
        AST_LVL_RESET: assert property (
            s_lvl_clear ##1 (!pend[i] and s_lvl_still) |=> pend[i])
            else $error("level flag not set again after clear");
        AST_HOLD_FLAG: assert property (
            pend[i] && !flag_clear_wr[i] |=> pend[i])
            else $error("flag dropped without a clear");
        AST_FILT_STEADY: assert property (
            ext_line_config[i].line_filter_enable && $changed(line_raw[i]) |=> $stable(filt_q))
            else $error("filter followed a one-cycle change");
    end

    assign ext_line_pending_flags = pend;
    assign ext_irq_req            = pend;

    // per pin, so one analog pin is enough to exercise it
    AST_ANALOG_ONE: assert property ((|pin_analog) ##2 1'b1 |->
        ($past(pin_analog, 2) & ~pin_lvl) == '0)
        else $error("analog pins did not read as one");

    // ----------------------------------------------------------------
    // debug config and status
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            debug_disable <= RST_DEBUG_DISABLE;
            debug_status  <= '{debugger_forced_flag: 1'b0, serial_wire_enabled_flag: 1'b0,
                               boot_pin_captured: RST_BOOT_CAPTURED};
        end else begin
            // cannot set while the debugger is active
            if (debug_config_wr && (!debug_disable_wdata || !debugger_active)) begin
                debug_disable <= debug_disable_wdata;
            end
            // status flags and boot pin capture
            debug_status.debugger_forced_flag     <= debugger_forced_in;
            debug_status.serial_wire_enabled_flag <= serial_wire_in;
            if (boot_sample) begin
                debug_status.boot_pin_captured <= boot_select_pin_n;
            end
        end
    end

    AST_DBG_LOCK: assert property (
        debug_config_wr && debug_disable_wdata && debugger_active |=> $stable(debug_disable))
        else $error("debug disable set while debugger active");
    AST_BOOT_CAP: assert property (
        boot_sample |=> debug_status.boot_pin_captured == $past(boot_select_pin_n))
        else $error("boot pin not captured");
    AST_STAT_MIRROR: assert property (1'b1 |=>
        debug_status.debugger_forced_flag == $past(debugger_forced_in) &&
        debug_status.serial_wire_enabled_flag == $past(serial_wire_in))
        else $error("debug status flags do not follow their inputs");

endmodule

// ---- dv/gwei_pin_model.sv ----
// external signal sources on the port pins for the wake and line bench
// assumes callers run on the falling-edge timeline of clk_sys
`timescale 1ns/1ps
module gwei_pin_model
    import gwei_pkg::*;
(
    input  wire logic           clk_sys,
    output logic [NUM_PINS-1:0] pin_in
);
    // pins are always driven hard, so no floating level is modelled
    initial pin_in = '0;

    task automatic set_pin(input int idx, input logic val);
        @(negedge clk_sys);
        pin_in[idx] = val;
    endtask

    task automatic set_all(input logic [NUM_PINS-1:0] val);
        @(negedge clk_sys);
        pin_in = val;
    endtask

    // glitch lasting cyc system cycles, then back to the old level
    task automatic pulse(input int idx, input int cyc);
        @(negedge clk_sys);
        pin_in[idx] = ~pin_in[idx];
        repeat (cyc) @(negedge clk_sys);
        pin_in[idx] = ~pin_in[idx];
    endtask
endmodule

// ---- dv/gpio_wake_and_ext_irq_bench.sv ----
// self-checking bench for the pin wake monitor and external lines
// assumes the pin model owns pin_in; all other inputs change at falling edges
`timescale 1ns/1ps
module gpio_wake_and_ext_irq_bench
    import gwei_pkg::*;
;
    localparam int TICK = 4;
    localparam int S    = 5;
    logic                  clk_sys = 1'b0;
    logic                  arst_n = 1'b0;
    logic [NUM_PINS-1:0]   pin_in;
    logic [NUM_PINS-1:0]   pin_analog = '0;
    logic [NUM_PINS-1:0]   pin_wake_mask = '0;
    gwei_wake_src_t        wake_src_select = '0;
    gwei_wake_src_t        wake_filter_enables = '0;
    logic                  serial_ctrl_one = 1'b0;
    logic                  serial_ctrl_two = 1'b0;
    logic                  sleep_active = 1'b0;
    gwei_line_cfg_t [3:0]  ext_line_config = '0;
    logic [SEL_W-1:0]      line_c_pin_select = '0;
    logic [SEL_W-1:0]      line_d_pin_select = '0;
    logic [NUM_LINES-1:0]  flag_clear_wr = '0;
    logic                  debug_config_wr = 1'b0;
    logic                  debug_disable_wdata = 1'b0;
    logic                  debugger_active = 1'b0;
    logic                  debugger_forced_in = 1'b0;
    logic                  serial_wire_in = 1'b0;
    logic                  boot_select_pin_n = 1'b1;
    logic                  boot_sample = 1'b0;
    logic                  wake_event;
    gwei_wake_src_t        wake_cause;
    logic [NUM_LINES-1:0]  pend;
    logic [NUM_LINES-1:0]  ext_irq_req;
    logic                  debug_disable;
    gwei_dbg_stat_t        debug_status;
    int                    failures = 0;
    int                    compares = 0;

    always #4 clk_sys = ~clk_sys;

    gwei_pin_model pins (.clk_sys, .pin_in);

    gwei_top #(.WAKE_TICK(TICK), .LINE_FILT(LINE_FILT_CYC)) dut (
        .clk_sys, .arst_n, .pin_in, .pin_analog, .pin_wake_mask, .wake_src_select,
        .wake_filter_enables, .serial_ctrl_one, .serial_ctrl_two, .sleep_active,
        .ext_line_config, .line_c_pin_select, .line_d_pin_select, .flag_clear_wr,
        .debug_config_wr, .debug_disable_wdata, .debugger_active, .debugger_forced_in,
        .serial_wire_in, .boot_select_pin_n, .boot_sample, .wake_event, .wake_cause,
        .ext_line_pending_flags(pend), .ext_irq_req, .debug_disable, .debug_status
    );

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic clr(input logic [NUM_LINES-1:0] m);
        flag_clear_wr = m;
        step(1);
        flag_clear_wr = '0;
    endtask

    // a wait that runs out while a wake is due ends the run
    task automatic wait_wake(input int n, input logic exp);
        int i;
        for (i = 0; i < n && wake_event !== 1'b1; i++) step(1);
        check(wake_event, exp, "wake event");
        if (exp && wake_event !== 1'b1) end_sim();
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic trig(input logic [2:0] m);
        logic e;
        ext_line_config[0] = '{1'b0, m};
        step(S);
        clr(4'hf);
        step(S);
        check({ext_irq_req[0], pend[0]}, {2{m == TRIG_LOW}}, "idle low"); // request
        pins.set_pin(LINE_A_PIN, 1'b1);
        step(S);
        e = m inside {TRIG_RISE, TRIG_BOTH, TRIG_HIGH, TRIG_LOW};
        check({ext_irq_req[0], pend[0]}, {2{e}}, "rise"); // mode
        clr(4'he);
        check(pend[0], e, "zero write"); // write zero
        step(1);
        clr(4'h1);
        check(pend[0], 1'b0, "cleared"); // write one
        step(1);
        check(pend[0], m == TRIG_HIGH, "level reset"); // re-set
        pins.set_pin(LINE_A_PIN, 1'b0);
        step(S);
        e = m inside {TRIG_FALL, TRIG_BOTH, TRIG_HIGH, TRIG_LOW};
        check(pend[0], e, "fall"); // mode
    endtask

    task automatic sel_scan();
        ext_line_config = '{4{'{1'b0, TRIG_RISE}}};
        for (int s = 0; s < NUM_PINS; s++) begin
            int t;
            t = (s + 1) % NUM_PINS;
            line_c_pin_select = SEL_W'(s);
            line_d_pin_select = SEL_W'(t);
            step(S);
            clr(4'hf);
            pins.set_pin(s, 1'b1);
            step(S);
            check(pend, {2'b01, s == LINE_B_PIN, s == LINE_A_PIN}, "sel c"); // map
            pins.set_pin(t, 1'b1);
            step(S);
            check(pend, {2'b11, s == LINE_B_PIN || t == LINE_B_PIN,
                         s == LINE_A_PIN || t == LINE_A_PIN}, "sel d"); // fixed
            pins.set_all('0);
        end
    endtask

    task automatic line_misc();
        // analog on a low pin forces a one, which is itself a rising edge
        clr(4'hf);
        pin_analog[LINE_B_PIN] = 1'b1;
        step(S);
        check(pend[1], 1'b1, "analog rise"); // constant one
        clr(4'hf);
        pins.pulse(LINE_B_PIN, 10);
        step(S);
        check(pend[1], 1'b0, "analog pin"); // no interrupt
        for (int k = 0; k < 3; k++) begin
            ext_line_config[0] = '{k > 0, TRIG_RISE};
            clr(4'hf);
            pins.pulse(LINE_A_PIN, k == 2 ? LINE_FILT_CYC + 4 : 10);
            step(LINE_FILT_CYC + S);
            check(pend[0], k != 1, "filter"); // widths
        end
    endtask

    task automatic nap(input logic [3:0] src, input logic [3:0] filt);
        wake_src_select = src;
        wake_filter_enables = filt;
        // let pin changes reach the synchronised level before the reference is taken
        step(S);
        sleep_active = 1'b1;
        step(S);
    endtask

    task automatic wake_tests();
        pin_wake_mask = 24'h000008;
        pins.set_pin(3, 1'b1);
        nap(4'h1, 4'h0);
        pins.set_pin(5, 1'b1);
        wait_wake(S, 1'b0); // masked out
        pins.set_pin(3, 1'b0);
        wait_wake(S, 1'b1); // any change
        check(wake_cause, 4'h1, "cause"); // group only
        sleep_active = 1'b0;
        step(2);
        check({wake_event, wake_cause}, 5'h01, "after sleep"); // sticky
        nap(4'h0, 4'h0);
        pins.set_pin(3, 1'b1);
        wait_wake(2 * S, 1'b0); // source bit
        sleep_active = 1'b0;
        step(2);
        nap(4'h1, 4'h1);
        check(wake_cause, 4'h0, "cause cleared"); // entry
        pins.pulse(3, 2);
        wait_wake(6 * TICK, 1'b0); // glitch
        pins.set_pin(3, 1'b0);
        wait_wake(4 * TICK + S, 1'b1); // three samples
        sleep_active = 1'b0;
        step(2);
        for (int n = 0; n < 4; n++) begin
            int g;
            g = n % 2 + 1;
            // last two passes run the serial groups through the sample filter, which ticks every TICK cycles here
            nap(4'(1 << g), n > 1 ? 4'(1 << g) : 4'h0);
            {serial_ctrl_two, serial_ctrl_one} = 2'(1 << (g - 1));
            wait_wake(n > 1 ? 4 * TICK + S : 2 * S, 1'b1); // serial groups
            check(wake_cause, 4'(1 << g), "serial cause"); // separate
            {serial_ctrl_two, serial_ctrl_one} = 2'b00;
            sleep_active = 1'b0;
            step(2);
        end
    endtask

    task automatic dbg_wr(input logic v, input logic act, input logic exp);
        debugger_active = act;
        debug_disable_wdata = v;
        step(1);
        debug_config_wr = 1'b1;
        step(1);
        debug_config_wr = 1'b0;
        check(debug_disable, exp, "debug disable"); // disable bit
    endtask

    initial begin
        step(8);
        arst_n = 1'b1;
        step(1);
        check({pend, ext_irq_req, wake_event, debug_disable, debug_status},
              {8'h00, 2'b00, 3'b001}, "reset values"); // reset
        for (int m = 0; m < 8; m++) trig(3'(m));
        sel_scan();
        line_misc();
        wake_tests();
        dbg_wr(1'b1, 1'b0, 1'b1);
        dbg_wr(1'b0, 1'b0, 1'b0);
        dbg_wr(1'b1, 1'b1, 1'b0);
        boot_select_pin_n = 1'b0;
        boot_sample = 1'b1;
        step(1);
        boot_sample = 1'b0;
        {debugger_forced_in, serial_wire_in} = 2'b11;
        step(2);
        check(debug_status, 3'b110, "debug status"); // status
        end_sim();
    end
endmodule
